// file: pkg/afp_pkg.sv
// shared constants, types and helpers for the converter protocol control
package afp_pkg;

  // ----------------------------------------------------------------
  // register indices on the serial control port
  // ----------------------------------------------------------------
  localparam logic [6:0] REG_TRIM_IDX  = 7'h40; // reference trim (64)
  localparam logic [6:0] REG_PD_FIRST  = 7'h42; // first power-down reg (66)
  localparam logic [6:0] REG_PD_LAST   = 7'h46; // last power-down reg (70)
  localparam logic [6:0] REG_CRC_IDX   = 7'h47; // checksum control (71)
  localparam logic [6:0] REG_DARK_IDX  = 7'h4a; // dark level dac code
  localparam logic [6:0] REG_MODE_IDX  = 7'h4b; // readout mode select
  localparam int         NUM_PD_REGS   = 5;     // power-down registers

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         TRIM_LSB      = 4;     // span field low bit
  localparam int         TRIM_MSB      = 6;     // span field high bit
  localparam logic [7:0] TRIM_RST      = 8'h70; // span code 111 (1.0x)
  localparam logic [7:0] PD_RST        = 8'h00; // all pairs powered on
  localparam int         CRC_DATA_BIT  = 0;     // checksum on data lanes
  localparam int         CRC_SYNC_BIT  = 1;     // checksum on sync lane
  localparam logic [7:0] CRC_CTL_RST   = 8'h01; // data on, sync off
  localparam logic [7:0] DARK_RST      = 8'hc0; // dac code for 1.5 V
  localparam logic [7:0] MODE_RST      = 8'h00; // normal readout

  // ----------------------------------------------------------------
  // timing: master clock periods
  // ----------------------------------------------------------------
  localparam int         ADC_DIV       = 8;     // converter clk = 1/8
  localparam int         WORD_DIV      = 4;     // word slot = 1/4
  localparam int         CONV_LAT_ADC  = 4;     // converter pipe depth
  localparam int         TOTAL_LAT     = 44;    // front end + converter
  localparam int         PIPE_STAGES   = (TOTAL_LAT + ADC_DIV - 1) / ADC_DIV;
  localparam int         SPI_BITS      = 16;    // write flag, addr, data

  // ----------------------------------------------------------------
  // row checksum
  // ----------------------------------------------------------------
  localparam logic [7:0] CRC_POLY      = 8'h4d; // x^8+x^6+x^3+x^2+1
  localparam logic [7:0] CRC_INIT      = 8'hff; // seed of every row
  localparam logic [7:0] TRAIN_WORD    = 8'h5a; // training pattern word

  // readout modes
  typedef enum logic [1:0] {
    AFP_MODE_NORMAL = 2'b00,
    AFP_MODE_TRAIN  = 2'b01,
    AFP_MODE_TEST   = 2'b10
  } afp_mode_e;

  // what a converter sample slot carries
  typedef enum logic [1:0] {
    AFP_SLOT_NONE  = 2'b00,
    AFP_SLOT_FIRST = 2'b01,
    AFP_SLOT_DATA  = 2'b10,
    AFP_SLOT_CRC   = 2'b11
  } afp_slot_e;

  // one byte through the serial checksum, msb first
  function automatic logic [7:0] afp_crc_byte(input logic [7:0] crc,
                                              input logic [7:0] din);
    logic [7:0] c;
    logic       fb;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      fb = c[7] ^ din[i];
      c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction

endpackage

// file: core/afp_ctrl.sv
// converter control, register port and lane protocol layer
module afp_ctrl import afp_pkg::*; #(
  parameter int NUM_LANE = 32,
  parameter int NUM_ADC  = 2 * NUM_LANE
) (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  // serial control port pins
  input  wire logic                   spi_clk_pin,
  input  wire logic                   spi_cs_n_pin,
  input  wire logic                   spi_mosi_pin,
  output logic                        spi_miso_o,
  output logic                        spi_miso_oe,
  // sequencer side
  input  wire logic                   row_active,
  input  wire logic [7:0]             sync_word,
  // raw converter results, 9 bits each
  input  wire logic [NUM_ADC*9-1:0]   adc_raw,
  // analog controls
  output logic                        adc_clk_en,
  output logic [2:0]                  ref_span_code,
  output logic [7:0]                  dark_level_code,
  output logic [NUM_LANE-1:0]         pair_power_down,
  // lanes towards the serializers
  output logic [NUM_LANE*8-1:0]       lane_data,
  output logic [NUM_LANE-1:0]         lane_valid,
  output logic                        lane_is_crc,
  output logic [7:0]                  sync_data,
  output logic                        sync_valid
);

  // ----------------------------------------------------------------
  // pin synchronisers and serial control port
  // ----------------------------------------------------------------
  logic [2:0] sclk_sy_q, sclk_sy_d;   // three stage clock sync
  logic [2:0] cs_sy_q,   cs_sy_d;     // three stage select sync
  logic [2:0] mosi_sy_q, mosi_sy_d;   // three stage data sync
  logic       sclk_lv_q, sclk_lv_d;   // accepted clock level
  logic       cs_lv_q,   cs_lv_d;     // accepted select level (low act)
  logic [4:0] bit_cnt_q, bit_cnt_d;   // bits taken in this frame
  logic [15:0] sh_in_q,  sh_in_d;     // incoming shift register
  logic [7:0] sh_out_q,  sh_out_d;    // read data shift register
  logic       sclk_rise, sclk_fall;   // accepted clock edges
  logic       wr_stb;                 // one-cycle register write
  logic [6:0] wr_idx;                 // register index to write
  logic [7:0] wr_val;                 // value to write
  logic [7:0] rd_val;                 // readback of addressed reg

  // synchroniser chains and edge decisions
  always_comb begin
    sclk_sy_d = {sclk_sy_q[1:0], spi_clk_pin};
    cs_sy_d   = {cs_sy_q[1:0], spi_cs_n_pin};
    mosi_sy_d = {mosi_sy_q[1:0], spi_mosi_pin};
    // a change counts once stages two and three agree
    sclk_lv_d = (sclk_sy_q[1] == sclk_sy_q[2]) ? sclk_sy_q[2] : sclk_lv_q;
    cs_lv_d   = (cs_sy_q[1] == cs_sy_q[2]) ? cs_sy_q[2] : cs_lv_q;
    sclk_rise = sclk_lv_d & ~sclk_lv_q & ~cs_lv_q;
    sclk_fall = ~sclk_lv_d & sclk_lv_q & ~cs_lv_q;
  end

  // frame shifting: write flag, 7-bit index, 8-bit data, msb first
  always_comb begin
    bit_cnt_d = bit_cnt_q;
    sh_in_d   = sh_in_q;
    sh_out_d  = sh_out_q;
    wr_stb    = 1'b0;
    if (cs_lv_q) begin
      // deselected: restart the frame
      bit_cnt_d = 5'h00;
    end else if (sclk_rise) begin
      sh_in_d   = {sh_in_q[14:0], mosi_sy_q[2]};
      bit_cnt_d = bit_cnt_q + 5'h01;
      // last bit of a write frame commits the register
      wr_stb    = (bit_cnt_q == 5'(SPI_BITS - 1)) && sh_in_q[14];
    end else if (sclk_fall) begin
      // address complete: load read data, else shift it out
      if (bit_cnt_q == 5'h08) begin
        sh_out_d = rd_val;
      end else if (bit_cnt_q > 5'h08) begin
        sh_out_d = {sh_out_q[6:0], 1'b0};
      end
    end
    wr_idx = sh_in_d[14:8];
    wr_val = sh_in_d[7:0];
  end

  // register the port state
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sclk_sy_q <= 3'h0;
      cs_sy_q   <= 3'h7;
      mosi_sy_q <= 3'h0;
      sclk_lv_q <= 1'b0;
      cs_lv_q   <= 1'b1;
      bit_cnt_q <= 5'h00;
      sh_in_q   <= 16'h0000;
      sh_out_q  <= 8'h00;
    end else begin
      sclk_sy_q <= sclk_sy_d;
      cs_sy_q   <= cs_sy_d;
      mosi_sy_q <= mosi_sy_d;
      sclk_lv_q <= sclk_lv_d;
      cs_lv_q   <= cs_lv_d;
      bit_cnt_q <= bit_cnt_d;
      sh_in_q   <= sh_in_d;
      sh_out_q  <= sh_out_d;
    end
  end

  assign spi_miso_o  = sh_out_q[7];
  assign spi_miso_oe = ~cs_lv_q;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [7:0] trim_q,    trim_d;            // reference trim register
  logic [7:0] pd_q [NUM_PD_REGS];           // power-down registers
  logic [7:0] pd_d [NUM_PD_REGS];
  logic [7:0] crc_ctl_q, crc_ctl_d;         // checksum enables
  logic [7:0] dark_q,    dark_d;            // dark level dac code
  logic [7:0] mode_q,    mode_d;            // readout mode register
  logic [NUM_PD_REGS*8-1:0] pd_flat;        // power-down bits, flat

  // write decode and readback
  always_comb begin
    trim_d    = trim_q;
    crc_ctl_d = crc_ctl_q;
    dark_d    = dark_q;
    mode_d    = mode_q;
    rd_val    = 8'h00;
    for (int i = 0; i < NUM_PD_REGS; i++) begin
      pd_d[i] = pd_q[i];
      pd_flat[i*8 +: 8] = pd_q[i];
      if (wr_stb && wr_idx == REG_PD_FIRST + 7'(i))
        pd_d[i] = wr_val;
      if (sh_in_q[6:0] == REG_PD_FIRST + 7'(i))
        rd_val = pd_q[i];
    end
    if (wr_stb) begin
      case (wr_idx)
        REG_TRIM_IDX: trim_d    = wr_val;
        REG_CRC_IDX:  crc_ctl_d = wr_val;
        REG_DARK_IDX: dark_d    = wr_val;
        REG_MODE_IDX: mode_d    = wr_val;
        default:      ;                                 // unmapped: ignored
      endcase
    end
    // readback on the index just shifted in
    case (sh_in_q[6:0])
      REG_TRIM_IDX: rd_val = trim_q;
      REG_CRC_IDX:  rd_val = crc_ctl_q;
      REG_DARK_IDX: rd_val = dark_q;
      REG_MODE_IDX: rd_val = mode_q;
      default:      ;                                   // power-down regs keep the loop value, others read zero
    endcase
  end

  // register file storage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trim_q    <= TRIM_RST;
      crc_ctl_q <= CRC_CTL_RST;
      dark_q    <= DARK_RST;
      mode_q    <= MODE_RST;
      for (int i = 0; i < NUM_PD_REGS; i++)
        pd_q[i] <= PD_RST;
    end else begin
      trim_q    <= trim_d;
      crc_ctl_q <= crc_ctl_d;
      dark_q    <= dark_d;
      mode_q    <= mode_d;
      for (int i = 0; i < NUM_PD_REGS; i++)
        pd_q[i] <= pd_d[i];
    end
  end

  assign ref_span_code   = trim_q[TRIM_MSB:TRIM_LSB];
  assign dark_level_code = dark_q;
  assign pair_power_down = pd_flat[NUM_LANE-1:0];

  // ----------------------------------------------------------------
  // converter clock divider and latency pipeline
  // ----------------------------------------------------------------
  logic [2:0]  div_q,  div_d;               // master clock divider
  logic        row_q,  row_d;               // row level at last tick
  logic [TOTAL_LAT+WORD_DIV-1:0] lat_q, lat_d; // sample tick delay line
  logic [NUM_ADC*9-1:0] pdat_q [PIPE_STAGES];  // samples in flight
  logic [NUM_ADC*9-1:0] pdat_d [PIPE_STAGES];
  afp_slot_e   pkind_q [PIPE_STAGES];       // slot kind in flight
  afp_slot_e   pkind_d [PIPE_STAGES];
  logic [7:0]  psync_q [PIPE_STAGES];       // sync word in flight
  logic [7:0]  psync_d [PIPE_STAGES];
  logic        even_slot, odd_slot;         // word slots at the output
  afp_slot_e   out_kind;                    // kind at the output stage

  // divider, row framing and sample stage shifting
  always_comb begin
    div_d      = div_q + 3'h1;
    adc_clk_en = (div_q == 3'(ADC_DIV - 1));
    row_d      = adc_clk_en ? row_active : row_q;
    lat_d      = {lat_q[TOTAL_LAT+WORD_DIV-2:0], adc_clk_en};
    for (int s = 0; s < PIPE_STAGES; s++) begin
      pdat_d[s]  = pdat_q[s];
      pkind_d[s] = pkind_q[s];
      psync_d[s] = psync_q[s];
    end
    if (adc_clk_en) begin
      // one stage per converter clock: four of them are the converter
      for (int s = PIPE_STAGES - 1; s > 0; s--) begin
        pdat_d[s]  = pdat_q[s-1];
        pkind_d[s] = pkind_q[s-1];
        psync_d[s] = psync_q[s-1];
      end
      pdat_d[0]  = adc_raw;
      psync_d[0] = sync_word;
      // first sample, later samples, or the checksum slot after a row
      if (row_active)
        pkind_d[0] = row_q ? AFP_SLOT_DATA : AFP_SLOT_FIRST;
      else
        pkind_d[0] = row_q ? AFP_SLOT_CRC : AFP_SLOT_NONE;
    end
    // even word 44 clocks after sampling, odd word one slot later
    even_slot = lat_q[TOTAL_LAT-1];
    odd_slot  = lat_q[TOTAL_LAT+WORD_DIV-1];
    out_kind  = pkind_q[PIPE_STAGES-1];
  end

  // pipeline registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      div_q <= 3'h0;
      row_q <= 1'b0;
      lat_q <= '0;
      for (int s = 0; s < PIPE_STAGES; s++) begin
        pdat_q[s]  <= '0;
        pkind_q[s] <= AFP_SLOT_NONE;
        psync_q[s] <= 8'h00;
      end
    end else begin
      div_q <= div_d;
      row_q <= row_d;
      lat_q <= lat_d;
      for (int s = 0; s < PIPE_STAGES; s++) begin
        pdat_q[s]  <= pdat_d[s];
        pkind_q[s] <= pkind_d[s];
        psync_q[s] <= psync_d[s];
      end
    end
  end

  // ----------------------------------------------------------------
  // readout mode and test pattern counter
  // ----------------------------------------------------------------
  afp_mode_e  mode_sel;                     // decoded readout mode
  logic [7:0] pat_q, pat_d;                 // test image counter
  logic       data_even, data_odd, crc_slot; // what the slot emits

  always_comb begin
    case (mode_q[1:0])
      2'b01:   mode_sel = AFP_MODE_TRAIN;
      2'b10:   mode_sel = AFP_MODE_TEST;
      default: mode_sel = AFP_MODE_NORMAL;
    endcase
    data_even = even_slot && (out_kind == AFP_SLOT_FIRST ||
                              out_kind == AFP_SLOT_DATA);
    data_odd  = odd_slot && (out_kind == AFP_SLOT_FIRST ||
                             out_kind == AFP_SLOT_DATA);
    crc_slot  = even_slot && out_kind == AFP_SLOT_CRC;
    pat_d     = (data_even || data_odd) ? pat_q + 8'h01 : pat_q;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) pat_q <= 8'h00;
    else        pat_q <= pat_d;
  end

  // ----------------------------------------------------------------
  // data lanes: pair mux, checksum, power-down hold
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_LANE; g++) begin : g_lane
    logic [7:0] word;                       // word offered this slot
    logic [7:0] crc_q, crc_d;               // running row checksum
    logic [7:0] out_q, out_d;               // lane data register
    logic       vld_q, vld_d;               // lane word strobe

    always_comb begin
      // eight msbs of the even or odd converter of this pair
      word = even_slot ? pdat_q[PIPE_STAGES-1][(2*g)*9+1 +: 8]
                       : pdat_q[PIPE_STAGES-1][(2*g+1)*9+1 +: 8];
      case (mode_sel)
        AFP_MODE_TRAIN: word = TRAIN_WORD;
        AFP_MODE_TEST:  word = pat_q + 8'(g);
        default:        ;
      endcase
      crc_d = crc_q;
      out_d = out_q;
      vld_d = 1'b0;
      if (!pair_power_down[g]) begin
        if (data_even || data_odd) begin
          out_d = word;
          vld_d = 1'b1;
          // a new row restarts from the seed
          crc_d = afp_crc_byte((data_even && out_kind == AFP_SLOT_FIRST)
                               ? CRC_INIT : crc_q, word);
        end else if (crc_slot) begin
          out_d = crc_q;
          vld_d = crc_ctl_q[CRC_DATA_BIT];
          crc_d = CRC_INIT;
        end
      end
      // powered down: word and checksum stay put, strobe stays low
    end

    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        crc_q <= CRC_INIT;
        out_q <= 8'h00;
        vld_q <= 1'b0;
      end else begin
        crc_q <= crc_d;
        out_q <= out_d;
        vld_q <= vld_d;
      end
    end

    assign lane_data[g*8 +: 8] = out_q;
    assign lane_valid[g]       = vld_q;
  end

  // ----------------------------------------------------------------
  // synchronization lane
  // ----------------------------------------------------------------
  logic [7:0] scrc_q, scrc_d;               // sync lane checksum
  logic [7:0] sout_q, sout_d;               // sync lane data register
  logic       svld_q, svld_d;               // sync lane strobe
  logic       crc_q_flag, crc_d_flag;       // current words are checksum

  // sync words ride the same latency so they line up with pixels
  always_comb begin
    scrc_d     = scrc_q;
    sout_d     = sout_q;
    svld_d     = 1'b0;
    crc_d_flag = 1'b0;
    if (data_even) begin
      sout_d = psync_q[PIPE_STAGES-1];
      svld_d = 1'b1;
      scrc_d = afp_crc_byte((out_kind == AFP_SLOT_FIRST) ? CRC_INIT
                            : scrc_q, psync_q[PIPE_STAGES-1]);
    end else if (crc_slot) begin
      sout_d     = scrc_q;
      svld_d     = crc_ctl_q[CRC_SYNC_BIT];
      scrc_d     = CRC_INIT;
      crc_d_flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scrc_q     <= CRC_INIT;
      sout_q     <= 8'h00;
      svld_q     <= 1'b0;
      crc_q_flag <= 1'b0;
    end else begin
      scrc_q     <= scrc_d;
      sout_q     <= sout_d;
      svld_q     <= svld_d;
      crc_q_flag <= crc_d_flag;
    end
  end

  assign sync_data   = sout_q;
  assign sync_valid  = svld_q;
  assign lane_is_crc = crc_q_flag;

endmodule

// file: dv/afp_ctrl_checker.sv
// port assertions for the converter protocol control
module afp_ctrl_checker #(
  parameter int NUM_LANE = 32,
  parameter int NUM_ADC  = 64
) (
  // clock and reset
  input wire logic                  sys_clk,
  input wire logic                  rst_n,
  // watched ports
  input wire logic                  row_active,
  input wire logic                  adc_clk_en,
  input wire logic [2:0]            ref_span_code,
  input wire logic [7:0]            dark_level_code,
  input wire logic [NUM_LANE-1:0]   pair_power_down,
  input wire logic [NUM_LANE*8-1:0] lane_data,
  input wire logic [NUM_LANE-1:0]   lane_valid,
  input wire logic                  lane_is_crc
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // reset values show on the first edge after release
  chk_dark_reset: assert property (
    $rose(rst_n) |-> dark_level_code == 8'hc0)
    else $error("dark level code not at startup value");
  chk_span_reset: assert property (
    $rose(rst_n) |-> ref_span_code == 3'b111)
    else $error("span code not at startup value");
  chk_pd_reset: assert property (
    $rose(rst_n) |-> pair_power_down == '0 && lane_valid == '0)
    else $error("pairs not powered on after reset");
  // converter tick every eighth master clock
  chk_tick_period: assert property (
    adc_clk_en |=> !adc_clk_en [*7] ##1 adc_clk_en)
    else $error("converter tick spacing wrong");
  // even word of a row tick leaves after the fixed latency
  chk_even_lat: assert property (
    adc_clk_en && row_active && !pair_power_down[0] |-> ##45 lane_valid[0])
    else $error("even word latency wrong");
  // odd word follows on the same lane one half tick later
  chk_odd_lat: assert property (
    adc_clk_en && row_active && !pair_power_down[0] |-> ##49 lane_valid[0])
    else $error("odd word latency wrong");
  // a powered-down lane stays quiet and frozen
  chk_pd_quiet: assert property (
    pair_power_down[0] && $past(pair_power_down[0])
    |-> !lane_valid[0] && $stable(lane_data[7:0]))
    else $error("powered-down lane moved");
  // checksum slot comes from the first idle tick after a row
  chk_crc_src: assert property (
    lane_is_crc |-> $past(adc_clk_en, 45) && !$past(row_active, 45))
    else $error("checksum slot without idle tick");
endmodule

bind afp_ctrl afp_ctrl_checker #(
  .NUM_LANE(NUM_LANE),
  .NUM_ADC (NUM_ADC)
) afp_ctrl_checker_inst (
  .sys_clk        (sys_clk),
  .rst_n          (rst_n),
  .row_active     (row_active),
  .adc_clk_en     (adc_clk_en),
  .ref_span_code  (ref_span_code),
  .dark_level_code(dark_level_code),
  .pair_power_down(pair_power_down),
  .lane_data      (lane_data),
  .lane_valid     (lane_valid),
  .lane_is_crc    (lane_is_crc)
);

// file: dv/afp_host_model.sv
// host model: serial control port master for register access
module afp_host_model (
  // clock
  input wire logic sys_clk,
  // serial port pins
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe,
  output logic     spi_clk_pin,
  output logic     spi_cs_n_pin,
  output logic     spi_mosi_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle pins at time zero
  initial begin
    spi_clk_pin  = 1'b0;
    spi_cs_n_pin = 1'b1;
    spi_mosi_pin = 1'b1;
  end
  // six clocks per half period stays above the five clock minimum
  task automatic half();
    repeat (6) @(posedge sys_clk);
  endtask
  // one 16-bit mode 0 frame, msb first; read bits taken on rising clock
  task automatic frame(input logic [15:0] w, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge sys_clk);
    spi_cs_n_pin <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi_pin <= w[i];
      half();
      spi_clk_pin <= 1'b1;
      if (i < 8) rd = {rd[6:0], spi_miso_oe ? spi_miso_o : 1'b0};
      half();
      spi_clk_pin <= 1'b0;
    end
    half();
    spi_cs_n_pin <= 1'b1;
    // released data line flips rather than holding its last bit
    spi_mosi_pin <= ~w[0];
    half();
  endtask
endmodule

// file: dv/afp_ctrl_tb_top.sv
// self-checking testbench for the converter protocol control
module afp_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // signals and captured traffic
  // ----------------------------------------------------------------
  logic         sys_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         row_active = 1'b0;
  logic [7:0]   sync_word = 8'h00;
  logic [575:0] adc_raw = '0;
  logic         spi_clk_pin, spi_cs_n_pin, spi_mosi_pin, spi_miso_o;
  logic         spi_miso_oe, adc_clk_en, lane_is_crc, sync_valid;
  logic [2:0]   ref_span_code;
  logic [7:0]   dark_level_code, sync_data, rd;
  logic [31:0]  pair_power_down, lane_valid;
  logic [255:0] lane_data;
  logic [8:0]   lq[2][$];  // lane words, bit 8 marks a checksum
  logic [8:0]   sq[$];     // sync words
  int           bad_count = 0;
  int           compares = 0;
  int           crc_seen = 0;
  bit           train = 0, pd0 = 0, crc_on = 1, sync_on = 0;
  bit           test = 0;   // test image mode: counter plus lane index
  initial forever #50 sys_clk = ~sys_clk;
  afp_ctrl afp_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .spi_clk_pin(spi_clk_pin), .spi_cs_n_pin(spi_cs_n_pin),
    .spi_mosi_pin(spi_mosi_pin), .spi_miso_o(spi_miso_o),
    .spi_miso_oe(spi_miso_oe), .row_active(row_active),
    .sync_word(sync_word), .adc_raw(adc_raw), .adc_clk_en(adc_clk_en),
    .ref_span_code(ref_span_code), .dark_level_code(dark_level_code),
    .pair_power_down(pair_power_down), .lane_data(lane_data),
    .lane_valid(lane_valid), .lane_is_crc(lane_is_crc),
    .sync_data(sync_data), .sync_valid(sync_valid));
  afp_host_model afp_host_model_inst (.sys_clk(sys_clk),
    .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe),
    .spi_clk_pin(spi_clk_pin), .spi_cs_n_pin(spi_cs_n_pin),
    .spi_mosi_pin(spi_mosi_pin));
  // capture on the falling edge, away from register updates
  always @(negedge sys_clk) begin
    for (int g = 0; g < 2; g++)
      if (lane_valid[g]) lq[g].push_back({lane_is_crc, lane_data[g*8 +: 8]});
    if (lane_is_crc) crc_seen++;
    // the sync lane runs whatever the pairs' power state
    if (sync_valid) sq.push_back({lane_is_crc, sync_data});
  end
  task automatic complete_run();
    if (bad_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // serial checksum, msb first, own copy of the polynomial
  function automatic logic [7:0] crc_step(logic [7:0] c, logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h4d : 8'h00);
    return c;
  endfunction
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    afp_host_model_inst.frame({1'b1, a, d}, rd);
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
    afp_host_model_inst.frame({1'b0, a, 8'h00}, rd);
    check(32'(rd), 32'(exp));
  endtask
  // return one clock before the edge that opens the next converter tick
  task automatic next_tick();
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
      if (n > 20) begin
        bad_count++;
        complete_run();
      end
    end while (!adc_clk_en);
    repeat (7) @(posedge sys_clk);
  endtask
  // n row ticks then one idle tick, then judge lanes 0 and 1 and sync
  task automatic run_row(input int n, input logic [8:0] base);
    logic [7:0] c, sc, w;
    logic [8:0] r;
    lq[0].delete();
    lq[1].delete();
    sq.delete();
    for (int k = 0; k <= n; k++) begin
      next_tick();
      row_active <= (k < n);
      sync_word  <= 8'h30 + 8'(k);
      for (int i = 0; i < 64; i++) adc_raw[i*9 +: 9] <= base + 9'(i + k);
    end
    repeat (60) @(posedge sys_clk);  // past the 49 clock odd latency
    for (int g = 0; g < 2; g++) begin
      c = 8'hff;
      if (g == 0 && pd0) begin
        check(lq[0].size(), 0);
        continue;
      end
      for (int j = 0; j < 2 * n; j++) begin
        r = base + 9'(2 * g + j % 2 + j / 2);
        w = train ? 8'h5a : test ? 8'(j + g) : r[8:1];
        check(32'(lq[g].pop_front()), {23'h0, 1'b0, w});
        c = crc_step(c, w);
      end
      if (crc_on) check(32'(lq[g].pop_front()), {23'h0, 1'b1, c});
      check(lq[g].size(), 0);
    end
    sc = 8'hff;
    for (int k = 0; k < n; k++) begin
      check(32'(sq.pop_front()), 32'(8'h30 + 8'(k)));
      sc = crc_step(sc, 8'h30 + 8'(k));
    end
    if (sync_on) check(32'(sq.pop_front()), {23'h0, 1'b1, sc});
  endtask
  task automatic t_reset();
    check(32'(ref_span_code), 32'h7);
    check(32'(dark_level_code), 32'hc0);
    check(32'(spi_miso_oe), 32'h0);
    check(pair_power_down, 0);
    rdc(7'h40, 8'h70);
    rdc(7'h42, 8'h00);
    rdc(7'h47, 8'h01);
    wr(7'h10, 8'h55);
    rdc(7'h10, 8'h00);
  endtask
  task automatic t_span_dark();
    for (int s = 0; s < 8; s++) begin
      wr(7'h40, {1'b0, 3'(s), 4'h0});
      check(32'(ref_span_code), 32'(s));
    end
    wr(7'h4a, 8'hc0 - 8'h12);
    check(32'(dark_level_code), 32'hae);
  endtask
  task automatic t_pd_modes();
    int n0;
    wr(7'h42, 8'h01);
    check(pair_power_down, 32'h1);
    pd0 = 1;
    run_row(2, 9'h040);
    pd0 = 0;
    wr(7'h42, 8'h00);
    wr(7'h45, 8'h80);
    check(pair_power_down, 32'h8000_0000);
    wr(7'h45, 8'h00);
    wr(7'h47, 8'h00);
    crc_on = 0;
    sync_on = 0;
    n0 = crc_seen;
    run_row(1, 9'h0aa);
    check(crc_seen - n0, 1);
    wr(7'h47, 8'h01);
    crc_on = 1;
    wr(7'h4b, 8'h01);
    train = 1;
    run_row(2, 9'h010);
    train = 0;
    wr(7'h4b, 8'h02);
    rdc(7'h4b, 8'h02);
    wr(7'h4b, 8'h00);
  endtask
  task automatic t_mid_reset();
    wr(7'h40, 8'h30);
    wr(7'h42, 8'hff);
    rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    check(32'(ref_span_code), 32'h7);
    check(pair_power_down, 0);
    check(32'(dark_level_code), 32'hc0);
    // test image row: the slot counter restarts with reset
    wr(7'h4b, 8'h02);
    test = 1;
    run_row(2, 9'h000);
    test = 0;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    t_reset();
    t_span_dark();
    wr(7'h47, 8'h03);
    sync_on = 1;
    run_row(3, 9'h1fc);
    run_row(3, 9'h1fc);
    t_pd_modes();
    t_mid_reset();
    complete_run();
  end
endmodule
